//--- rtl/srtc_cfg.svh
`ifndef SRTC_CFG_SVH
`define SRTC_CFG_SVH

// register byte offsets
`define SRTC_ADDR_CTRL   8'h00
`define SRTC_ADDR_CMD    8'h04
`define SRTC_ADDR_COUNT  8'h08
`define SRTC_ADDR_PTR    8'h0C
`define SRTC_ADDR_DATA   8'h10
`define SRTC_ADDR_STAT   8'h14
`define SRTC_ADDR_DIV    8'h18

// field positions
`define SRTC_CTRL_START  0
`define SRTC_STAT_BUSY   0
`define SRTC_STAT_DONE   1
`define SRTC_STAT_ERR    2
`define SRTC_CMD_VALID   7
`define SRTC_CMD_RAM     6
`define SRTC_CMD_READ    0

// reset values
`define SRTC_CMD_RESET   8'h81
`define SRTC_COUNT_RESET 6'h01
`define SRTC_PTR_RESET   5'h00

// limits
`define SRTC_MAX_BYTES   6'h20
`define SRTC_DIV_MIN     8'h04

// timing
`define SRTC_CLK_MHZ     125
`define SRTC_HALF_NS     500
`define SRTC_HALF_CYC    ((`SRTC_HALF_NS * `SRTC_CLK_MHZ + 999) / 1000)

`endif

//--- rtl/srtc_host.sv
// Notes on behaviour
// - command bit 7 must be one
// - command bit 6 picks clock or RAM
// - bits 1-5 address, bit 0 direction
// - host shifts command LSB first, eight cycles
// - transfer select high frames every transfer
// - data valid at rise, device drives at fall
// - shift clock low when select rises
// - write byte follows command, LSB first
// - address 31 selects burst mode
// - clock burst write needs all eight bytes
// - protect blocks writes; clear it first
`include "srtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module srtc_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        xfer_sel,
  output var  logic        shift_clk,
  input  wire logic        data_in,
  output var  logic        data_out,
  output var  logic        data_oe
);

  srtc_pkg::srtc_state_t state;

  logic [7:0]  data_mem [0:31];
  logic [7:0]  cmd;
  logic [5:0]  count;
  logic [4:0]  ptr;
  logic [7:0]  half_div;
  logic        done;
  logic        err;
  logic [7:0]  tmr;
  logic [7:0]  shreg;
  logic [2:0]  bit_idx;
  logic [5:0]  byte_idx;
  logic        in_cmd;
  logic        io_sync;
  logic        busy;
  logic        rd_xfer;
  logic        half_end;
  logic        half_mid;
  logic        acc_c;
  logic        wr_c;
  logic        rd_c;
  logic        wr_ok;
  logic        start;
  logic        start_busy;
  logic        fin_c;
  logic        store;
  logic        last;
  logic [5:0]  next_byte;
  logic [7:0]  next_data;
  logic        hit_c;
  logic [31:0] rdata_c;

  srtc_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (data_in),
    .q     (io_sync)
  );

  // link reads land in the buffer only after all eight bits of a byte
  // have been shifted in; a frame cut short leaves the buffer slot as it was
  // write bytes are sent whole, so a clock burst is complete only when
  // software asks for eight data bytes; fewer bytes commit nothing there
  assign busy       = (state != srtc_pkg::ST_IDLE);
  assign rd_xfer    = cmd[`SRTC_CMD_READ];
  assign half_end   = (tmr == half_div - 8'h01);
  assign half_mid   = (tmr == {1'b0, half_div[7:1]});
  assign acc_c      = psel & penable & pready;
  assign wr_c       = acc_c & pwrite;
  assign rd_c       = acc_c & ~pwrite;
  assign wr_ok      = wr_c & ~busy;
  assign start      = wr_ok & (paddr == `SRTC_ADDR_CTRL) & pwdata[`SRTC_CTRL_START];
  assign start_busy = wr_c & busy & (paddr == `SRTC_ADDR_CTRL) & pwdata[`SRTC_CTRL_START];
  assign fin_c      = (state == srtc_pkg::ST_GAP) & half_end;
  assign store      = (state == srtc_pkg::ST_HIGH) & half_end & ~in_cmd & rd_xfer
                      & (bit_idx == 3'h7);
  assign next_byte  = in_cmd ? 6'h00 : byte_idx + 6'h01;
  assign next_data  = data_mem[next_byte[4:0]];
  assign last       = in_cmd ? (count == 6'h00) : (byte_idx + 6'h01 == count);

  // apb answer: one wait state, then pready for one cycle
  // the wait state gives the decode and buffer read a full cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_comb
  begin
    hit_c   = 1'b1;
    rdata_c = 32'h0000_0000;
    case (paddr)
      `SRTC_ADDR_CTRL:  rdata_c = 32'h0000_0000;
      `SRTC_ADDR_CMD:   rdata_c = {24'h00_0000, cmd};
      `SRTC_ADDR_COUNT: rdata_c = {26'h000_0000, count};
      `SRTC_ADDR_PTR:   rdata_c = {27'h000_0000, ptr};
      `SRTC_ADDR_DATA:  rdata_c = {24'h00_0000, data_mem[ptr]};
      `SRTC_ADDR_STAT:  rdata_c = {29'h0000_0000, err, done, busy};
      `SRTC_ADDR_DIV:   rdata_c = {24'h00_0000, half_div};
      default:          hit_c   = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_c;
      pslverr <= ~hit_c;
    end
    else
      pslverr <= 1'b0;
  end

  // transfer setup, frozen while a transfer runs
  // the command goes out as written apart from its top bit, so the
  // protect bit of the far side is cleared by software with an ordinary
  // single write to the control address before any other write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd      <= `SRTC_CMD_RESET;
      count    <= `SRTC_COUNT_RESET;
      half_div <= 8'(`SRTC_HALF_CYC);
    end
    else if (wr_ok)
    begin
      case (paddr)
        `SRTC_ADDR_CMD:   cmd <= pwdata[7:0];
        `SRTC_ADDR_COUNT: count <= (pwdata[5:0] > `SRTC_MAX_BYTES) ? `SRTC_MAX_BYTES
                                   : pwdata[5:0];
        `SRTC_ADDR_DIV:   half_div <= (pwdata[7:0] < `SRTC_DIV_MIN) ? `SRTC_DIV_MIN
                                      : pwdata[7:0];
        default:          cmd <= cmd;
      endcase
    end
  end

  // buffer pointer, steps after each data window read, and after each data window write made while idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr <= `SRTC_PTR_RESET;
    else if (wr_c & (paddr == `SRTC_ADDR_PTR))
      ptr <= pwdata[4:0];
    else if ((rd_c | wr_ok) & (paddr == `SRTC_ADDR_DATA))
      ptr <= ptr + 5'h01;
  end

  // byte buffer: link reads land here, link writes come from here
  // no reset: contents stay unknown until software or the link fills them
  always_ff @(posedge pclk)
  begin
    if (store)
      data_mem[byte_idx[4:0]] <= shreg;
    else if (wr_ok & (paddr == `SRTC_ADDR_DATA))
      data_mem[ptr] <= pwdata[7:0];
  end

  // sticky flags, set wins over clear
  // done rises only after the select line has been low for a half period,
  // so software may start the next frame as soon as it sees done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done <= 1'b0;
    else if (fin_c)
      done <= 1'b1;
    else if (wr_c & (paddr == `SRTC_ADDR_STAT) & pwdata[`SRTC_STAT_DONE])
      done <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err <= 1'b0;
    else if (start_busy)
      err <= 1'b1;
    else if (wr_c & (paddr == `SRTC_ADDR_STAT) & pwdata[`SRTC_STAT_ERR])
      err <= 1'b0;
  end

  // serial engine
  // each shift clock half lasts half_div cycles; data changes only when
  // the clock falls or the select line rises, and read bits are taken at the end of the low half,
  // after the two-stage synchroniser has settled on the line level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= srtc_pkg::ST_IDLE;
      tmr       <= 8'h00;
      shreg     <= 8'h00;
      bit_idx   <= 3'h0;
      byte_idx  <= 6'h00;
      in_cmd    <= 1'b0;
      xfer_sel  <= 1'b0;
      shift_clk <= 1'b0;
      data_out  <= 1'b0;
      data_oe   <= 1'b0;
    end
    else
    begin
      tmr <= tmr + 8'h01;
      case (state)
        srtc_pkg::ST_IDLE:
        begin
          tmr <= 8'h00;
          if (start)
          begin
            xfer_sel  <= 1'b1;
            shift_clk <= 1'b0;
            shreg     <= {1'b1, cmd[6:0]};
            data_out  <= cmd[0];
            data_oe   <= 1'b1;
            in_cmd    <= 1'b1;
            bit_idx   <= 3'h0;
            byte_idx  <= 6'h00;
            state     <= srtc_pkg::ST_LOW;
          end
        end
        srtc_pkg::ST_LOW:
        begin
          if (half_end)
          begin
            tmr       <= 8'h00;
            shift_clk <= 1'b1;
            if (!in_cmd & rd_xfer)
              shreg <= {io_sync, shreg[7:1]};
            state <= srtc_pkg::ST_HIGH;
          end
        end
        srtc_pkg::ST_HIGH:
        begin
          // let go of the line well before the device drives it
          if (half_mid & in_cmd & rd_xfer & (bit_idx == 3'h7))
            data_oe <= 1'b0;
          if (half_end)
          begin
            tmr       <= 8'h00;
            shift_clk <= 1'b0;
            bit_idx   <= bit_idx + 3'h1;
            if (bit_idx != 3'h7)
            begin
              state <= srtc_pkg::ST_LOW;
              if (in_cmd | ~rd_xfer)
              begin
                shreg    <= {1'b0, shreg[7:1]};
                data_out <= shreg[1];
              end
            end
            else
            begin
              in_cmd <= 1'b0;
              if (!in_cmd)
                byte_idx <= byte_idx + 6'h01;
              if (last)
              begin
                data_oe <= 1'b0;
                state   <= srtc_pkg::ST_STOP;
              end
              else
              begin
                state <= srtc_pkg::ST_LOW;
                if (!rd_xfer)
                begin
                  shreg    <= next_data;
                  data_out <= next_data[0];
                  data_oe  <= 1'b1;
                end
              end
            end
          end
        end
        srtc_pkg::ST_STOP:
        begin
          if (half_end)
          begin
            tmr      <= 8'h00;
            xfer_sel <= 1'b0;
            state    <= srtc_pkg::ST_GAP;
          end
        end
        srtc_pkg::ST_GAP:
        begin
          if (half_end)
          begin
            tmr   <= 8'h00;
            state <= srtc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          xfer_sel  <= 1'b0;
          shift_clk <= 1'b0;
          data_oe   <= 1'b0;
          state     <= srtc_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule // srtc_host

`default_nettype wire

//--- rtl/srtc_pkg.sv
package srtc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW  = 5'h02,
    ST_HIGH = 5'h04,
    ST_STOP = 5'h08,
    ST_GAP  = 5'h10
  } srtc_state_t;

endpackage

//--- rtl/srtc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module srtc_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);

  logic meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // srtc_sync

`default_nettype wire

//--- test/srtc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module srtc_dev (
  input  wire logic xfer_sel,
  input  wire logic shift_clk,
  input  wire logic line,
  output var  logic dout,
  output var  logic doe
);
  logic [7:0] mem [64];
  logic [7:0] cmd = 8'h00;
  logic [7:0] sr  = 8'h00;
  logic [5:0] a   = 6'h00;
  int         n   = 0;
  initial doe = 1'b0;
  initial dout = 1'b0;
  always @(posedge shift_clk or negedge shift_clk or negedge xfer_sel)
    if (!xfer_sel)
    begin
      n = 0;
      doe <= 1'b0;
    end
    else if (shift_clk)
    begin
      doe <= 1'b0;
      sr = {line, sr[7:1]};
      n = n + 1;
      if (n == 8)
      begin
        cmd = sr;
        a = {sr[6], (&sr[5:1]) ? 5'h00 : sr[5:1]};
      end
      else if (n % 8 == 0 && !cmd[0] && cmd[7] && (n == 16 || &cmd[5:1]))
      begin
        mem[a] = sr;
        a = a + 6'h01;
      end
    end
    else if (n >= 8 && cmd[0])
    begin
      dout <= mem[a][(n - 8) % 8];
      doe <= 1'b1;
      if ((n - 8) % 8 == 7 && &cmd[5:1])
        a = a + 6'h01;
    end
endmodule // srtc_dev
`default_nettype wire

//--- test/srtc_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module srtc_host_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        xfer_sel,
  input wire logic        shift_clk,
  input wire logic        data_in,
  input wire logic        data_out,
  input wire logic        data_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_sel_clk_low: assert property ($rose(xfer_sel) |-> !shift_clk && data_oe)
    else $error("clock high at select");
  a_clk_idle: assert property (!xfer_sel |-> !shift_clk)
    else $error("clock runs outside frame");
  a_data_on_fall: assert property ($changed(data_out) |->
    $fell(shift_clk) || $changed(xfer_sel) || !xfer_sel)
    else $error("data changed off falling edge");
  a_low_half: assert property ($rose(shift_clk) |-> !$past(shift_clk, 3))
    else $error("low half too short");
  a_high_half: assert property ($fell(shift_clk) |-> $past(shift_clk, 3))
    else $error("high half too short");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_frame: cover property ($rose(xfer_sel));
  c_rd_out: cover property ($fell(data_oe) && xfer_sel);
  c_err: cover property (pslverr);
endmodule // srtc_host_chk
bind srtc_host srtc_host_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_sel(xfer_sel),
  .shift_clk(shift_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xfer_sel;
  logic        shift_clk;
  logic        data_out;
  logic        data_oe;
  logic        dev_out;
  logic        dev_oe;
  wire         line = data_oe ? data_out : dev_oe ? dev_out : ~data_out;
  int          err_count = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        se;
  always #4 pclk = ~pclk;
  srtc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xfer_sel(xfer_sel), .shift_clk(shift_clk),
    .data_in(line), .data_out(data_out), .data_oe(data_oe));
  srtc_dev dev (.xfer_sel(xfer_sel), .shift_clk(shift_clk), .line(line),
    .dout(dev_out), .doe(dev_oe));
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic [5:0] cnt);
    int k;
    apb(1'b1, 8'h04, {24'h0, c});
    apb(1'b1, 8'h08, {26'h0, cnt});
    apb(1'b1, 8'h00, 32'h1);
    k = 0;
    do
    begin
      apb(1'b0, 8'h14, 32'h0);
      k++;
    end
    while (rd[1] !== 1'b1 && k < 400);
    if (k >= 400)
    begin
      err_count++;
      end_sim();
    end
    apb(1'b1, 8'h14, 32'h2);
  endtask
  task automatic t_reset;
    apb(1'b0, 8'h04, 32'h0);
    chk("cmd", rd, 32'h81);
    apb(1'b0, 8'h08, 32'h0);
    chk("count", rd, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("div", rd, 32'h3F);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {31'h0, se}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_single;
    apb(1'b1, 8'h18, 32'h4);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h5A);
    xfer(8'hC4, 6'h01);
    chk("ram2", {24'h0, dev.mem[34]}, 32'h5A);
    dev.mem[34] = 8'hA6;
    xfer(8'hC5, 6'h01);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("rd byte", rd, 32'hA6);
    $display("test single done");
  endtask
  task automatic t_burst;
    int i;
    apb(1'b1, 8'h0C, 32'h0);
    for (i = 0; i < 3; i++)
      apb(1'b1, 8'h10, 32'h11 * (i + 1));
    xfer(8'hFE, 6'h03);
    for (i = 0; i < 3; i++)
      chk("burst wr", {24'h0, dev.mem[32 + i]}, 32'h11 * (i + 1));
    dev.mem[33] = 8'hC3;
    xfer(8'hFF, 6'h03);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("burst rd0", rd, 32'h11);
    apb(1'b0, 8'h10, 32'h0);
    chk("burst rd1", rd, 32'hC3);
    $display("test burst done");
  endtask
  task automatic t_msb;
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h77);
    xfer(8'h02, 6'h01);
    chk("cmd msb", {24'h0, dev.cmd}, 32'h82);
    chk("clk1", {24'h0, dev.mem[1]}, 32'h77);
    $display("test msb done");
  endtask
  task automatic t_busy;
    int k;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("stat busy err", {29'h0, rd[2:0]}, 32'h5);
    k = 0;
    do
    begin
      apb(1'b0, 8'h14, 32'h0);
      k++;
    end
    while (rd[1] !== 1'b1 && k < 400);
    if (k >= 400)
    begin
      err_count++;
      end_sim();
    end
    apb(1'b1, 8'h14, 32'h6);
    apb(1'b0, 8'h14, 32'h0);
    chk("stat clear", rd, 32'h0);
    $display("test busy done");
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_burst();
    t_msb();
    t_busy();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
